/* File: shared/sio_consts.svh */
// constants for the line-interface i/o port
`ifndef SIO_CONSTS_SVH
`define SIO_CONSTS_SVH

// register offsets on the serial control port
`define SIO_OFS_DIR_L 7'h00
`define SIO_OFS_DIR_H 7'h01
`define SIO_OFS_CHAN0_PIN_DATA_LOW 7'h02
`define SIO_OFS_CHAN3_PIN_DATA_HIGH 7'h09
`define SIO_OFS_CONFIGURATION_REGISTER 7'h20

// reset values
`define SIO_DIR_RESET 12'h000
`define SIO_DATA_RESET 12'h000
`define SIO_CONFIGURATION_REGISTER_RESET 8'hBF
`define SIO_PINS_RESET 16'h000F
`define SIO_SER_IDLE 3'h4

// field positions
`define SIO_CONFIGURATION_REGISTER_STATIC_BIT 4
`define SIO_CMD_READ_BIT 7

// serial framing and select scan timing
`define SIO_BYTE_BITS 4'h8
`define SIO_CS_WINDOW 8
`define SIO_CS_WINDOW_MIN 6
`define SIO_CS_WINDOW_MAX 255

`endif

/* File: shared/sio_pkg.sv */
// types shared by the line-interface i/o port
package sio_pkg;

    // pin group: twelve line pins and four select lines
    typedef struct packed {
        logic [11:0] io;
        logic [3:0] sel;
    } sio_pins_t;

    // register write strobe with its address and data
    typedef struct packed {
        logic wr;
        logic [6:0] addr;
        logic [7:0] data;
    } sio_wr_t;

    // serial access phase: command byte or data byte
    typedef enum logic {
        SIO_PH_CMD,
        SIO_PH_DATA
    } sio_phase_t;

endpackage : sio_pkg

/* File: core/sio_ser_slave.sv */
// serial control port slave: command byte then one data byte per access
`timescale 1ns/1ps
`include "sio_consts.svh"
module sio_ser_slave (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // serial control pins
    input wire logic i_ctl_cs_n,
    input wire logic i_ctl_sclk,
    input wire logic i_ctl_sdi,
    output logic o_ctl_sdo,
    output logic o_ctl_sdo_oe,
    // register side
    output sio_pkg::sio_wr_t o_wr,
    output logic [6:0] o_rd_addr,
    input wire logic [7:0] i_rd_data
);
    import sio_pkg::*;

    //--------------------------------------------------------
    // pin synchronisers, order {cs_n, sclk, sdi}
    //--------------------------------------------------------
    logic [2:0] sa_r, sa_nxt, sb_r, sb_nxt, sc_r, sc_nxt;
    logic [2:0] flt_r, flt_nxt;
    logic ck_prev_r, ck_prev_nxt, cs_prev_r, cs_prev_nxt;
    logic ck_rise, ck_fall, cs_fall, cs_rise;

    always_comb begin
        sa_nxt = {i_ctl_cs_n, i_ctl_sclk, i_ctl_sdi};
        sb_nxt = sa_r;
        sc_nxt = sb_r;
        for (int i = 0; i < 3; i++) begin
            flt_nxt[i] = (sb_r[i] == sc_r[i]) ? sc_r[i] : flt_r[i];
        end
        ck_prev_nxt = flt_r[1];
        cs_prev_nxt = flt_r[2];
        ck_rise = flt_r[1] & ~ck_prev_r;
        ck_fall = ~flt_r[1] & ck_prev_r;
        cs_fall = ~flt_r[2] & cs_prev_r;
        cs_rise = flt_r[2] & ~cs_prev_r;
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sa_r <= `SIO_SER_IDLE;
            sb_r <= `SIO_SER_IDLE;
            sc_r <= `SIO_SER_IDLE;
            flt_r <= `SIO_SER_IDLE;
            ck_prev_r <= 1'b0;
            cs_prev_r <= 1'b1;
        end else begin
            sa_r <= sa_nxt;
            sb_r <= sb_nxt;
            sc_r <= sc_nxt;
            flt_r <= flt_nxt;
            ck_prev_r <= ck_prev_nxt;
            cs_prev_r <= cs_prev_nxt;
        end
    end

    //--------------------------------------------------------
    // byte framing and access decode
    //--------------------------------------------------------
    sio_phase_t phase_r, phase_nxt;
    logic [7:0] sh_r, sh_nxt, out_r, out_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [6:0] addr_r, addr_nxt;
    logic rd_r, rd_nxt, oe_r, oe_nxt;
    sio_wr_t wr_r, wr_nxt;

    always_comb begin
        phase_nxt = phase_r;
        sh_nxt = sh_r;
        cnt_nxt = cnt_r;
        addr_nxt = addr_r;
        rd_nxt = rd_r;
        out_nxt = out_r;
        oe_nxt = oe_r;
        wr_nxt = wr_r;
        wr_nxt.wr = 1'b0;
        if (cs_fall) begin
            cnt_nxt = 4'h0;
            if (phase_r == SIO_PH_DATA && rd_r) begin
                out_nxt = i_rd_data;
                oe_nxt = 1'b1;
            end
        end else if (!flt_r[2] && ck_rise) begin
            sh_nxt = {sh_r[6:0], flt_r[0]};
            if (cnt_r <= `SIO_BYTE_BITS) begin
                cnt_nxt = cnt_r + 4'h1;
            end
        end else if (!flt_r[2] && ck_fall && oe_r) begin
            out_nxt = {out_r[6:0], 1'b0};
        end
        if (cs_rise) begin
            oe_nxt = 1'b0;
            if (cnt_r != `SIO_BYTE_BITS) begin
                phase_nxt = SIO_PH_CMD;
            end else if (phase_r == SIO_PH_CMD) begin
                addr_nxt = sh_r[6:0];
                rd_nxt = sh_r[`SIO_CMD_READ_BIT];
                phase_nxt = SIO_PH_DATA;
            end else begin
                phase_nxt = SIO_PH_CMD;
                if (!rd_r) begin
                    wr_nxt.wr = 1'b1;
                    wr_nxt.addr = addr_r;
                    wr_nxt.data = sh_r;
                end
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            phase_r <= SIO_PH_CMD;
            sh_r <= 8'h00;
            cnt_r <= 4'h0;
            addr_r <= 7'h00;
            rd_r <= 1'b0;
            out_r <= 8'h00;
            oe_r <= 1'b0;
            wr_r <= '0;
        end else begin
            phase_r <= phase_nxt;
            sh_r <= sh_nxt;
            cnt_r <= cnt_nxt;
            addr_r <= addr_nxt;
            rd_r <= rd_nxt;
            out_r <= out_nxt;
            oe_r <= oe_nxt;
            wr_r <= wr_nxt;
        end
    end

    assign o_ctl_sdo = out_r[7];
    assign o_ctl_sdo_oe = oe_r;
    assign o_wr = wr_r;
    assign o_rd_addr = addr_r;

endmodule : sio_ser_slave

/* File: core/sio_slic_port.sv */
// line-interface i/o port: pin direction, per-channel data and select scan
//------------------------------------------------------------
// Contract
// - direction bit 0 makes the pin an input captured into data
// - direction bit 1 drives the pin from the data bit
// - reset clears direction and data, so every pin is an input
// - configuration bit 4 low selects dynamic mode, high static mode
// - dynamic: channel 0 window drives output pins from channel 0 data
// - dynamic: channel 0 window captures input pins into channel 0 data
// - dynamic: channels 1 to 3 behave alike in their own windows
// - static: channel 0 data drives output pins without any window
// - static: input pin levels copied continuously into channel 0 data
// - static: select lines become i/o, direction from channel 1 low bits
// - static: input select line level recorded in channel 2 low bits
// - static: output select line driven from channel 2 low bits
// - channel 3 data is pin data only in dynamic mode
// - static: channel 3 bit high blocks that select line's change request
// - static: unmasked input select line change raises a request
//------------------------------------------------------------
`timescale 1ns/1ps
`include "sio_consts.svh"
module sio_slic_port #(
    parameter int CS_WINDOW = `SIO_CS_WINDOW
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // serial control port
    input wire logic i_ctl_cs_n,
    input wire logic i_ctl_sclk,
    input wire logic i_ctl_sdi,
    output logic o_ctl_sdo,
    output logic o_ctl_sdo_oe,
    // line pins and select lines
    input wire sio_pkg::sio_pins_t i_pins,
    output sio_pkg::sio_pins_t o_pins,
    output sio_pkg::sio_pins_t o_pins_oe,
    // select line change request
    output logic o_sel_change_req
);
    import sio_pkg::*;

    //--------------------------------------------------------
    // parameter check
    //--------------------------------------------------------
    if (CS_WINDOW < `SIO_CS_WINDOW_MIN || CS_WINDOW > `SIO_CS_WINDOW_MAX) begin : g_bad_window
        $error("CS_WINDOW out of range");
    end

    localparam logic [7:0] WIN_LAST = 8'(CS_WINDOW - 1);

    //--------------------------------------------------------
    // serial control port
    //--------------------------------------------------------
    sio_wr_t wr;
    logic [6:0] rd_addr;
    logic [7:0] rd_data;

    sio_ser_slave u_ser (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_ctl_cs_n(i_ctl_cs_n),
        .i_ctl_sclk(i_ctl_sclk),
        .i_ctl_sdi(i_ctl_sdi),
        .o_ctl_sdo(o_ctl_sdo),
        .o_ctl_sdo_oe(o_ctl_sdo_oe),
        .o_wr(wr),
        .o_rd_addr(rd_addr),
        .i_rd_data(rd_data)
    );

    //--------------------------------------------------------
    // pin synchronisers
    //--------------------------------------------------------
    sio_pins_t pin_s1_r, pin_s1_nxt, pin_s2_r, pin_s2_nxt, pin_s3_r, pin_s3_nxt;
    sio_pins_t pin_f_r, pin_f_nxt;
    logic [3:0] sel_prev_r, sel_prev_nxt;

    always_comb begin
        pin_s1_nxt = i_pins;
        pin_s2_nxt = pin_s1_r;
        pin_s3_nxt = pin_s2_r;
        for (int i = 0; i < 16; i++) begin
            pin_f_nxt[i] = (pin_s2_r[i] == pin_s3_r[i]) ? pin_s3_r[i] : pin_f_r[i];
        end
        sel_prev_nxt = pin_f_r.sel;
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_s1_r <= `SIO_PINS_RESET;
            pin_s2_r <= `SIO_PINS_RESET;
            pin_s3_r <= `SIO_PINS_RESET;
            pin_f_r <= `SIO_PINS_RESET;
            sel_prev_r <= 4'hF;
        end else begin
            pin_s1_r <= pin_s1_nxt;
            pin_s2_r <= pin_s2_nxt;
            pin_s3_r <= pin_s3_nxt;
            pin_f_r <= pin_f_nxt;
            sel_prev_r <= sel_prev_nxt;
        end
    end

    //--------------------------------------------------------
    // select scan for dynamic mode
    //--------------------------------------------------------
    logic [11:0] dir_r, dir_nxt;
    logic [7:0] configuration_register_r, configuration_register_nxt;
    logic [11:0] data_r [4];
    logic [11:0] data_nxt [4];
    logic [1:0] chan_r, chan_nxt;
    logic [7:0] win_r, win_nxt;
    logic static_mode;
    logic dyn_cap;

    assign static_mode = configuration_register_r[`SIO_CONFIGURATION_REGISTER_STATIC_BIT];
    assign dyn_cap = !static_mode && (win_r == WIN_LAST);

    always_comb begin
        chan_nxt = chan_r;
        win_nxt = win_r;
        if (static_mode) begin
            chan_nxt = 2'h0;
            win_nxt = 8'h00;
        end else if (win_r == WIN_LAST) begin
            win_nxt = 8'h00;
            chan_nxt = chan_r + 2'h1;
        end else begin
            win_nxt = win_r + 8'h01;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            chan_r <= 2'h0;
            win_r <= 8'h00;
        end else begin
            chan_r <= chan_nxt;
            win_r <= win_nxt;
        end
    end

    //--------------------------------------------------------
    // registers
    //--------------------------------------------------------
    always_comb begin
        dir_nxt = dir_r;
        configuration_register_nxt = configuration_register_r;
        if (wr.wr && wr.addr == `SIO_OFS_DIR_L) begin
            dir_nxt[7:0] = wr.data;
        end
        if (wr.wr && wr.addr == `SIO_OFS_DIR_H) begin
            dir_nxt[11:8] = wr.data[3:0];
        end
        if (wr.wr && wr.addr == `SIO_OFS_CONFIGURATION_REGISTER) begin
            configuration_register_nxt = wr.data;
        end
    end

    for (genvar ch = 0; ch < 4; ch++) begin : g_chan
        localparam logic [6:0] OFS_L = 7'(`SIO_OFS_CHAN0_PIN_DATA_LOW + 2 * ch);
        localparam logic [6:0] OFS_H = 7'(`SIO_OFS_CHAN0_PIN_DATA_LOW + 2 * ch + 1);
        always_comb begin
            data_nxt[ch] = data_r[ch];
            if (wr.wr && wr.addr == OFS_L) begin
                data_nxt[ch][7:0] = wr.data;
            end
            if (wr.wr && wr.addr == OFS_H) begin
                data_nxt[ch][11:8] = wr.data[3:0];
            end
            if (dyn_cap && chan_r == 2'(ch)) begin
                data_nxt[ch] = (data_nxt[ch] & dir_r) | (pin_f_r.io & ~dir_r);
            end
            if (static_mode && ch == 0) begin
                data_nxt[ch] = (data_nxt[ch] & dir_r) | (pin_f_r.io & ~dir_r);
            end
            if (static_mode && ch == 2) begin
                data_nxt[ch][3:0] = (data_nxt[ch][3:0] & data_r[1][3:0]) | (pin_f_r.sel & ~data_r[1][3:0]);
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dir_r <= `SIO_DIR_RESET;
            configuration_register_r <= `SIO_CONFIGURATION_REGISTER_RESET;
            for (int i = 0; i < 4; i++) begin
                data_r[i] <= `SIO_DATA_RESET;
            end
        end else begin
            dir_r <= dir_nxt;
            configuration_register_r <= configuration_register_nxt;
            for (int i = 0; i < 4; i++) begin
                data_r[i] <= data_nxt[i];
            end
        end
    end

    //--------------------------------------------------------
    // read mux
    //--------------------------------------------------------
    logic [2:0] rd_idx;

    always_comb begin
        rd_data = 8'h00;
        rd_idx = 3'(rd_addr - `SIO_OFS_CHAN0_PIN_DATA_LOW);
        if (rd_addr == `SIO_OFS_DIR_L) begin
            rd_data = dir_r[7:0];
        end else if (rd_addr == `SIO_OFS_DIR_H) begin
            rd_data = {4'h0, dir_r[11:8]};
        end else if (rd_addr >= `SIO_OFS_CHAN0_PIN_DATA_LOW && rd_addr <= `SIO_OFS_CHAN3_PIN_DATA_HIGH) begin
            rd_data = rd_idx[0] ? {4'h0, data_r[rd_idx[2:1]][11:8]} : data_r[rd_idx[2:1]][7:0];
        end else if (rd_addr == `SIO_OFS_CONFIGURATION_REGISTER) begin
            rd_data = configuration_register_r;
        end
    end

    //--------------------------------------------------------
    // pin drive and change request
    //--------------------------------------------------------
    sio_pins_t out_r, out_nxt, oe_r, oe_nxt;
    logic req_r, req_nxt;
    logic [3:0] sel_chg;

    always_comb begin
        oe_nxt.io = dir_r;
        if (static_mode) begin
            out_nxt.io = data_r[0] & dir_r;
            oe_nxt.sel = data_r[1][3:0];
            out_nxt.sel = data_r[2][3:0] & data_r[1][3:0];
        end else begin
            out_nxt.io = data_r[chan_r] & dir_r;
            oe_nxt.sel = 4'hF;
            out_nxt.sel = ~(4'h1 << chan_r);
        end
        sel_chg = (pin_f_r.sel ^ sel_prev_r) & ~data_r[1][3:0];
        req_nxt = static_mode && |(sel_chg & ~data_r[3][3:0]);
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            out_r <= `SIO_PINS_RESET;
            oe_r <= '0;
            req_r <= 1'b0;
        end else begin
            out_r <= out_nxt;
            oe_r <= oe_nxt;
            req_r <= req_nxt;
        end
    end

    assign o_pins = out_r;
    assign o_pins_oe = oe_r;
    assign o_sel_change_req = req_r;

    //--------------------------------------------------------
    // assertions
    //--------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    reset_clear_a: assert property ($rose(i_rst_n) |-> dir_r == 12'h000 && data_r[0] == 12'h000)
        else $error("direction or data not cleared by reset");

    io_oe_dir_a: assert property (##1 o_pins_oe.io == $past(dir_r))
        else $error("io enable does not follow direction");

    static_drive_a: assert property (static_mode |=> o_pins.io == $past(data_r[0] & dir_r))
        else $error("static drive mismatch");

    dyn_select_a: assert property (!static_mode |=> o_pins.sel == ~(4'h1 << $past(chan_r)) && o_pins_oe.sel == 4'hF)
        else $error("dynamic select pattern wrong");

    dyn_drive_a: assert property (!static_mode && chan_r == 2'h0 |=> o_pins.io == $past(data_r[0] & dir_r))
        else $error("channel 0 window drive wrong");

    dyn_capture_a: assert property (dyn_cap && chan_r == 2'h0 |=> ((data_r[0] ^ $past(pin_f_r.io)) & $past(~dir_r)) == 12'h000)
        else $error("channel 0 capture wrong");

    dyn_cycle_a: assert property (!static_mode && dyn_cap && !$past(static_mode) |=> chan_r == $past(chan_r) + 2'h1)
        else $error("select scan did not advance");

    static_copy_a: assert property (static_mode |=> ((data_r[0] ^ $past(pin_f_r.io)) & $past(~dir_r)) == 12'h000)
        else $error("static copy wrong");

    sel_dir_a: assert property (static_mode |=> o_pins_oe.sel == $past(data_r[1][3:0]))
        else $error("select direction wrong");

    sel_capture_a: assert property (static_mode |=> ((data_r[2][3:0] ^ $past(pin_f_r.sel)) & $past(~data_r[1][3:0])) == 4'h0)
        else $error("select capture wrong");

    sel_drive_a: assert property (static_mode |=> (o_pins.sel & o_pins_oe.sel) == $past(data_r[2][3:0] & data_r[1][3:0]))
        else $error("select drive wrong");

    sel_mask_a: assert property (o_sel_change_req |-> $past(static_mode && |(sel_chg & ~data_r[3][3:0])))
        else $error("masked change raised request");

    sel_irq_a: assert property (static_mode && |(sel_chg & ~data_r[3][3:0]) |=> o_sel_change_req)
        else $error("change request missing");

    hi_zero_a: assert property (rd_addr >= `SIO_OFS_CHAN0_PIN_DATA_LOW && rd_addr <= `SIO_OFS_CHAN3_PIN_DATA_HIGH && rd_idx[0] |-> rd_data[7:4] == 4'h0)
        else $error("high nibble not zero");

endmodule : sio_slic_port

/* File: sim/sio_slic_model.sv */
// far-side model: four line circuits sharing the i/o lines
`timescale 1ns/1ps
module sio_slic_model
    import sio_pkg::*;
(
    // clock and mode
    input wire logic i_core_clk,
    input wire logic i_static,
    // levels each circuit presents
    input wire logic [3:0][11:0] i_chan_val,
    input wire logic [3:0] i_sel_val,
    // device pin side
    input wire sio_pkg::sio_pins_t i_dev_pins,
    input wire sio_pkg::sio_pins_t i_dev_oe,
    output sio_pkg::sio_pins_t o_line,
    output logic [3:0][11:0] o_seen
);
    logic [11:0] last_r = 12'h000;
    logic [11:0] drv;
    logic drv_on;
    logic [3:0] sel_q = 4'hF;
    // unselected circuits release the lines: show the inverse of the last driven level
    always_comb begin
        drv = ~last_r;
        drv_on = i_static;
        if (i_static) begin
            drv = i_chan_val[0];
        end
        for (int n = 0; n < 4; n++) begin
            if (!i_static && !i_dev_pins.sel[n]) begin
                drv = i_chan_val[n];
                drv_on = 1'b1;
            end
        end
    end
    assign o_line.io = (i_dev_oe.io & i_dev_pins.io) | (~i_dev_oe.io & drv);
    assign o_line.sel = (i_dev_oe.sel & i_dev_pins.sel) | (~i_dev_oe.sel & i_sel_val);
    // each circuit latches the driven lines while it stays selected
    always @(posedge i_core_clk) begin
        if (drv_on) begin
            last_r <= drv;
        end
        sel_q <= i_dev_pins.sel;
        for (int n = 0; n < 4; n++) begin
            if (!i_static && !i_dev_pins.sel[n] && !sel_q[n]) begin
                o_seen[n] <= i_dev_pins.io & i_dev_oe.io;
            end
        end
    end
endmodule : sio_slic_model

/* File: sim/tb_sio_slic_port.sv */
// testbench for the line-interface i/o port
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_sio_slic_port;
    import sio_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic cs_n = 1'b1;
    logic sclk = 1'b0;
    logic sdi = 1'b0;
    logic stat = 1'b1;
    logic sdo, sdo_oe, req;
    logic [3:0][11:0] chan_val = '0;
    logic [3:0][11:0] seen;
    logic [3:0] sel_val = 4'h0;
    sio_pins_t dev_pins, dev_oe, line;
    int fail_count = 0;
    int n_compared = 0;
    int req_count = 0;
    always #20 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) if (req === 1'b1) req_count++;
    sio_slic_port #(.CS_WINDOW(8)) i_sio_slic_port (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_ctl_cs_n(cs_n), .i_ctl_sclk(sclk), .i_ctl_sdi(sdi), .o_ctl_sdo(sdo), .o_ctl_sdo_oe(sdo_oe),
        .i_pins(line), .o_pins(dev_pins), .o_pins_oe(dev_oe), .o_sel_change_req(req));
    sio_slic_model i_sio_slic_model (.i_core_clk(i_core_clk), .i_static(stat), .i_chan_val(chan_val),
        .i_sel_val(sel_val), .i_dev_pins(dev_pins), .i_dev_oe(dev_oe), .o_line(line), .o_seen(seen));
    task automatic clks(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask : clks
    // one byte per select frame, msb first
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        cs_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            sdi = tx[i];
            clks(10);
            rx[i] = sdo_oe ? sdo : 1'bx;
            sclk = 1'b1;
            clks(10);
            sclk = 1'b0;
        end
        clks(10);
        cs_n = 1'b1;
        clks(12);
    endtask : xfer
    task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] rx;
        xfer({1'b0, a}, rx);
        xfer(d, rx);
    endtask : reg_wr
    task automatic reg_rd(input logic [6:0] a, output logic [7:0] d);
        logic [7:0] rx;
        xfer({1'b1, a}, rx);
        xfer(8'h00, d);
    endtask : reg_rd
    task automatic t_reset();
        logic [7:0] d;
        `CHK(dev_oe, 16'h0000)
        for (int a = 0; a < 10; a++) begin
            reg_rd(7'(a), d);
            `CHK(d, 8'h00)
        end
        reg_rd(7'h30, d);
        `CHK(d, 8'h00)
        reg_rd(7'h20, d);
        `CHK(d, 8'hBF)
    endtask : t_reset
    task automatic t_static_io();
        logic [7:0] d;
        chan_val[0] = 12'h3C3;
        reg_wr(7'h00, 8'h0F);
        reg_wr(7'h01, 8'hF5);
        reg_wr(7'h02, 8'hA5);
        reg_wr(7'h03, 8'h0A);
        clks(4);
        `CHK(dev_oe.io, 12'h50F)
        `CHK(dev_pins.io, 12'h005)
        reg_rd(7'h02, d);
        `CHK(d, 8'hC5)
        reg_rd(7'h03, d);
        `CHK(d, 8'h02)
        reg_rd(7'h01, d);
        `CHK(d, 8'h05)
    endtask : t_static_io
    task automatic t_static_sel();
        logic [7:0] d;
        int base;
        reg_wr(7'h04, 8'h03);
        reg_wr(7'h06, 8'h02);
        reg_wr(7'h08, 8'h00);
        sel_val = 4'b0100;
        clks(8);
        `CHK(dev_oe.sel, 4'h3)
        `CHK(dev_pins.sel[1:0], 2'b10)
        reg_rd(7'h06, d);
        `CHK(d, 8'h06)
        base = req_count;
        sel_val[3] = 1'b1;
        clks(40);
        `CHK(req_count - base, 1)
        reg_wr(7'h08, 8'h08);
        base = req_count;
        sel_val = 4'b0100;
        clks(40);
        `CHK(req_count - base, 0)
    endtask : t_static_sel
    task automatic t_dynamic();
        logic [7:0] d;
        reg_wr(7'h20, 8'hAF);
        stat = 1'b0;
        reg_rd(7'h20, d);
        `CHK(d, 8'hAF)
        for (int n = 0; n < 4; n++) begin
            chan_val[n] = {4'(n + 1), 4'(8 + n), 4'h0};
            reg_wr(7'(2 * n + 2), 8'(n + 1));
            reg_wr(7'(2 * n + 3), 8'h0F);
        end
        clks(200);
        for (int n = 0; n < 4; n++) begin
            `CHK(seen[n], 12'(12'h500 + n + 1))
            reg_rd(7'(2 * n + 2), d);
            `CHK(d, {4'(8 + n), 4'(n + 1)})
            reg_rd(7'(2 * n + 3), d);
            `CHK(d, {4'h0, (4'(n + 1) & 4'hA) | 4'h5})
        end
        `CHK(seen[0], 12'h501)
    endtask : t_dynamic
    task automatic complete_run();
        $display("compared %0d, failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    initial begin
        clks(12);
        i_rst_n = 1'b1;
        clks(4);
        t_reset();
        t_static_io();
        t_static_sel();
        t_dynamic();
        complete_run();
    end
    initial begin
        clks(90000);
        fail_count++;
        complete_run();
    end
endmodule : tb_sio_slic_port
